// [hw/tmr_event_counter.sv]
// 8-bit timer/event counter with timer, event and pulse width modes
// assumes a byte register port on clk_i; tick inputs are one-cycle enables on clk_i
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module tmr_event_counter
  import tmr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // register port
  input wire logic [0:0] addr_i,
  input wire logic [tmr_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [tmr_pkg::DATA_W-1:0] rdata_o,
  // internal clock sources, one-cycle ticks
  input wire logic sys_tick_i,
  input wire logic sub_tick_i,
  // power state and interrupt controller
  input wire logic low_power_i,
  input wire logic irq_enable_i,
  input wire logic irq_flag_i,
  input wire logic irq_flag_set_i,
  input wire logic irq_flag_clr_i,
  // count pin
  input wire logic count_input_pin_i,
  // results
  output logic irq_req_o,
  output logic irq_vector_o,
  output logic wake_o,
  output logic overflow_o
);
  import tmr_pkg::*;

  typedef struct packed {
    logic [7:0] counter;
    logic [7:0] preload;
    logic [1:0] mode;
    logic clock_source_select;
    logic count_run_bit;
    logic edge_polarity_bit;
    logic [2:0] prescale_select;
    logic measuring;
    logic irq_flag;
    logic irq_vec;
    logic wake;
    logic ovf;
    logic [7:0] rdata;
    logic pin_event;
  } state_type;
  state_type s, next_s;

  logic psc_tick, pin_level, pin_rise, pin_fall;
  logic active_edge, end_edge, step, ovf_now, blocked;

  // internal clock source picks system or sub clock tick
  tmr_prescaler tmr_prescaler_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .src_tick_i(s.clock_source_select ? sub_tick_i : sys_tick_i),
    .sel_i(s.prescale_select),
    .tick_o(psc_tick)
  );

  tmr_pin_sync tmr_pin_sync_inst (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .pin_i(count_input_pin_i),
    .level_o(pin_level),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // edge choice from polarity; start edge and the opposite stop edge
  always_comb begin
    active_edge = s.edge_polarity_bit ? pin_fall : pin_rise;
    if (s.mode == MODE_PULSE) begin
      active_edge = s.edge_polarity_bit ? pin_rise : pin_fall;
    end
    end_edge = s.edge_polarity_bit ? pin_fall : pin_rise;
    blocked = (rd_i && addr_i == ADDR_COUNT) || (wr_i && addr_i == ADDR_COUNT);
    unique case (s.mode)
      MODE_TIMER: step = s.count_run_bit && psc_tick;
      MODE_EVENT: step = s.count_run_bit && s.pin_event;
      MODE_PULSE: step = s.count_run_bit && s.measuring && psc_tick;
      default: step = 1'b0;
    endcase
    step = step && !blocked;
    ovf_now = step && (s.counter == COUNT_MAX);
  end

  // one state update: registers, counting, pulse sequencing
  always_comb begin
    next_s = s;
    next_s.ovf = 1'b0;
    next_s.irq_vec = 1'b0;
    next_s.wake = 1'b0;
    next_s.rdata = 8'h00;
    // pin edges are caught and held until the next counter step
    next_s.pin_event = s.pin_event;
    if (s.mode == MODE_EVENT && active_edge) begin
      next_s.pin_event = 1'b1;
    end
    if (step || s.mode != MODE_EVENT) begin
      next_s.pin_event = active_edge && s.mode == MODE_EVENT && step;
    end
    // counting and overflow reload in timer, event and pulse modes; mode code 0 never steps
    if (ovf_now) begin
      next_s.counter = s.preload;
      next_s.ovf = 1'b1;
      next_s.wake = low_power_i;
    end else if (step) begin
      next_s.counter = s.counter + 8'h01;
    end
    // pulse width sequencing: arm, start on edge, stop on return edge
    if (s.mode == MODE_PULSE && s.count_run_bit) begin
      if (!s.measuring && active_edge) begin
        next_s.measuring = 1'b1;
      end else if (s.measuring && end_edge) begin
        next_s.measuring = 1'b0;
        next_s.count_run_bit = 1'b0;
      end
    end
    if (!s.count_run_bit) begin
      next_s.measuring = 1'b0; // disarmed: pin ignored
    end
    // request flag: hardware set wins over clear
    if (irq_flag_clr_i) begin
      next_s.irq_flag = 1'b0;
    end
    if (irq_flag_set_i || ovf_now) begin
      next_s.irq_flag = 1'b1;
    end
    next_s.irq_vec = ovf_now && irq_enable_i;
    // software flag already set suppresses wake, as for halt entry
    if (irq_flag_i && s.irq_flag) begin
      next_s.wake = 1'b0;
    end
    // register writes; run only via software outside pulse mode
    if (wr_i) begin
      unique case (addr_i)
        ADDR_COUNT: begin
          next_s.preload = wdata_i;
          if (!s.count_run_bit) begin
            next_s.counter = wdata_i;
          end
        end
        ADDR_CTRL: begin
          next_s.mode = wdata_i[POS_MODE_HI:POS_MODE_LO];
          next_s.clock_source_select = wdata_i[POS_SRC];
          next_s.count_run_bit = wdata_i[POS_RUN];
          next_s.edge_polarity_bit = wdata_i[POS_EDGE];
          next_s.prescale_select = wdata_i[POS_PSC_HI:POS_PSC_LO];
          next_s.measuring = 1'b0;
        end
      endcase
    end
    // read data in the cycle after the strobe
    if (rd_i) begin
      unique case (addr_i)
        ADDR_COUNT: next_s.rdata = s.counter;
        ADDR_CTRL: next_s.rdata = {s.mode, s.clock_source_select, s.count_run_bit,
          s.edge_polarity_bit, s.prescale_select};
      endcase
    end
  end

  // all state held by the clock enable
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
      s.edge_polarity_bit <= CTRL_RESET[POS_EDGE];
      s.counter <= COUNT_RESET;
      s.preload <= COUNT_RESET;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign irq_req_o = s.irq_flag;
  assign irq_vector_o = s.irq_vec;
  assign wake_o = s.wake;
  assign overflow_o = s.ovf;

  // overflow reloads the preload value
  property p_reload;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && ovf_now && !wr_i) |=> (s.counter == $past(s.preload) && overflow_o);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow");

  // overflow always sets the request flag
  property p_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && ovf_now) |=> irq_req_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set on overflow");

  // software-only run clear outside pulse mode
  property p_run_kept;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.count_run_bit && s.mode != MODE_PULSE && !wr_i) |=> s.count_run_bit;
  endproperty
  a_run_kept: assert property (p_run_kept) else $error("run cleared by hardware");

  // blocked access freezes counter unless written
  property p_block;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && rd_i && addr_i == ADDR_COUNT && !wr_i) |=> $stable(s.counter);
  endproperty
  a_block: assert property (p_block) else $error("count moved during read");

  // armed but idle pulse counter does not move
  property p_armed;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.mode == MODE_PULSE && !s.measuring && !wr_i) |=> $stable(s.counter);
  endproperty
  a_armed: assert property (p_armed) else $error("counted before start edge");

  // stop edge clears run bit
  property p_stop;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.mode == MODE_PULSE && s.measuring && end_edge && !wr_i) |=> !s.count_run_bit;
  endproperty
  a_stop: assert property (p_stop) else $error("pulse end missed");

  // stopped preload write goes straight in
  property p_preload;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && wr_i && addr_i == ADDR_COUNT && !s.count_run_bit) |=> s.counter == $past(wdata_i);
  endproperty
  a_preload: assert property (p_preload) else $error("preload not direct");

  // wake in low power on overflow regardless of enable
  property p_wake;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && ovf_now && low_power_i && !(irq_flag_i && s.irq_flag)) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on overflow");

  // software clear drops the flag when no set competes
  property p_flag_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && irq_flag_clr_i && !irq_flag_set_i && !ovf_now) |=> !irq_req_o;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");

  // enabled overflow raises the vector pulse
  property p_vec;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && ovf_now && irq_enable_i) |=> irq_vector_o;
  endproperty
  a_vec: assert property (p_vec) else $error("no vector on overflow");

  // no vector while the interrupt is disabled
  property p_no_vec;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !irq_enable_i) |=> !irq_vector_o;
  endproperty
  a_no_vec: assert property (p_no_vec) else $error("vector while disabled");

  // wake only comes out of low power
  property p_no_wake_awake;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !low_power_i) |=> !wake_o;
  endproperty
  a_no_wake_awake: assert property (p_no_wake_awake) else $error("wake while awake");

  // running preload write only reaches the preload, counter frozen
  property p_held_preload;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && wr_i && addr_i == ADDR_COUNT && s.count_run_bit) |=>
      (s.preload == $past(wdata_i) && $stable(s.counter));
  endproperty
  a_held_preload: assert property (p_held_preload) else $error("preload not held");

  // timer mode steps by one on each divided tick
  property p_timer_step;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.mode == MODE_TIMER && s.count_run_bit && psc_tick && !blocked &&
      s.counter != COUNT_MAX && !wr_i) |=> s.counter == $past(s.counter) + 8'h01;
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer step lost");

  // event mode steps by one on a pending pin edge
  property p_event_step;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.mode == MODE_EVENT && s.count_run_bit && s.pin_event && !blocked &&
      s.counter != COUNT_MAX && !wr_i) |=> s.counter == $past(s.counter) + 8'h01;
  endproperty
  a_event_step: assert property (p_event_step) else $error("event step lost");

  // stopped counter holds its value
  property p_stopped;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !s.count_run_bit && !wr_i) |=> $stable(s.counter);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped counter moved");

  // armed pulse counter starts on the active edge
  property p_start;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && s.mode == MODE_PULSE && s.count_run_bit && !s.measuring && active_edge && !wr_i)
      |=> s.measuring;
  endproperty
  a_start: assert property (p_start) else $error("start edge missed");

  // read data stands only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !rd_i) |=> rdata_o == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("stale read data");

  // overflow pulse only after a real wrap
  property p_ovf_only;
    @(posedge clk_i) disable iff (sys_rst_i)
    (ce_i && !ovf_now) |=> !overflow_o;
  endproperty
  a_ovf_only: assert property (p_ovf_only) else $error("spurious overflow");
endmodule // tmr_event_counter

// [hw/tmr_pkg.sv]
// timer/event counter package: register offsets, field positions, reset values
// assumes a byte-wide register port with two registers
package tmr_pkg;
  localparam int DATA_W = 8;
  localparam logic [0:0] ADDR_COUNT = 1'h0; // counter / preload
  localparam logic [0:0] ADDR_CTRL = 1'h1;  // control
  localparam int POS_MODE_HI = 7;
  localparam int POS_MODE_LO = 6;
  localparam int POS_SRC = 5;
  localparam int POS_RUN = 4;
  localparam int POS_EDGE = 3;
  localparam int POS_PSC_HI = 2;
  localparam int POS_PSC_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam int PSC_W = 7;
endpackage

// [hw/tmr_prescaler.sv]
// prescaler: divides the selected timer input clock enable by 2^sel
// assumes src_tick_i is a one-cycle pulse in the clk_i domain
`timescale 1ns/100ps
module tmr_prescaler
  import tmr_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // control
  input wire logic src_tick_i,
  input wire logic [2:0] sel_i,
  // result
  output logic tick_o
);
  typedef struct packed {
    logic [PSC_W-1:0] div;
    logic tick;
  } state_type;
  state_type s, next_s;
  logic [PSC_W:0] mask;

  // divide codes 0..7 give /1../128: a tick when low sel bits all wrap to zero
  always_comb begin
    mask = (8'h01 << sel_i) - 8'h01;
    next_s = s;
    next_s.tick = 1'b0;
    if (src_tick_i) begin
      next_s.div = s.div + 7'h01;
      next_s.tick = ((s.div & mask[PSC_W-1:0]) == mask[PSC_W-1:0]);
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign tick_o = s.tick;
endmodule // tmr_prescaler

// [hw/tmr_pin_sync.sv]
// two-stage synchroniser with edge detection for the count pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/100ps
module tmr_pin_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // pin
  input wire logic pin_i,
  // edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } state_type;
  state_type s, next_s;

  // only sync and last feed the edge logic, never meta
  always_comb begin
    next_s.meta = pin_i;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s <= 3'h0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign level_o = s.sync;
  assign rise_o = s.sync & ~s.last;
  assign fall_o = ~s.sync & s.last;
endmodule // tmr_pin_sync

// [tb/pin_source.sv]
// pulse/event source model for the count pin
// assumes the bench clock; the pin moves just after a rising edge
`timescale 1ns/100ps
module pin_source (
  // clock
  input wire logic clk_i,
  // command
  input wire logic go_i,
  input wire logic [7:0] edges_i,
  input wire logic [7:0] gap_i,
  // pin and status
  output logic pin_o,
  output logic busy_o
);
  logic [7:0] left = 8'h00;
  logic [7:0] cnt = 8'h00;
  initial pin_o = 1'b0;
  // toggle every gap cycles; a real driver holds its last level
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= edges_i;
      cnt <= gap_i;
    end else if (left != 8'h00) begin
      if (cnt <= 8'h01) begin
        pin_o <= ~pin_o;
        left <= left - 8'h01;
        cnt <= gap_i;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end
  assign busy_o = go_i || (left != 8'h00);
endmodule // pin_source

// [tb/test_tmr_event_counter.sv]
// bench for the timer/event counter: register tasks, pin source, bounded waits
// assumes a 125 MHz clock and sys_tick_i as the timer input clock
`timescale 1ns/100ps
module test_tmr_event_counter;
  import tmr_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [0:0] addr_i = 1'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sys_tick_i = 1'b1;
  logic low_power_i = 1'b0;
  logic irq_enable_i = 1'b0;
  logic irq_flag_i = 1'b0;
  logic irq_flag_set_i = 1'b0;
  logic irq_flag_clr_i = 1'b0;
  logic go = 1'b0;
  logic [7:0] edges = 8'h00;
  logic [7:0] gap = 8'h01;
  logic [7:0] rdata_o, d;
  logic pin, busy, irq_req_o, irq_vector_o, wake_o, overflow_o, saw_wake, saw_vec;
  int n_mismatch = 0;
  int num_checks = 0;
  tmr_event_counter tmr_event_counter_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sys_tick_i(sys_tick_i), .sub_tick_i(1'b0), .low_power_i(low_power_i),
    .irq_enable_i(irq_enable_i), .irq_flag_i(irq_flag_i), .irq_flag_set_i(irq_flag_set_i),
    .irq_flag_clr_i(irq_flag_clr_i), .count_input_pin_i(pin), .irq_req_o(irq_req_o),
    .irq_vector_o(irq_vector_o), .wake_o(wake_o), .overflow_o(overflow_o));
  pin_source pin_source_inst (.clk_i(clk_i), .go_i(go), .edges_i(edges), .gap_i(gap),
    .pin_o(pin), .busy_o(busy));
  // 8 ns clock
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] lo, input logic [7:0] hi,
                       input logic [7:0] got);
    num_checks++;
    if ((^got === 1'bx) || !(got >= lo && got <= hi)) begin
      $display("MISMATCH %s exp %h..%h got %h", name, lo, hi, got);
      n_mismatch++;
    end
  endtask
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [0:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [0:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic toggle(input logic [7:0] n, input logic [7:0] g);
    @(posedge clk_i);
    edges <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    for (int i = 0; i < 2000 && busy; i++) @(posedge clk_i);
    if (busy) begin
      n_mismatch++;
      end_sim();
    end
    repeat (6) @(posedge clk_i);
  endtask
  // bounded wait for an overflow, noting wake and vector pulses
  task automatic wait_ovf();
    int i;
    saw_wake = 1'b0;
    saw_vec = 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_i);
      #1;
      saw_wake |= (wake_o === 1'b1);
      saw_vec |= (irq_vector_o === 1'b1);
      if (overflow_o === 1'b1) break;
    end
    if (i == 400) begin
      n_mismatch++;
      end_sim();
    end
    repeat (2) @(posedge clk_i);
  endtask
  // one measurement: arm, check idle, pulse, check result and later pins ignored
  task automatic pulse(input logic [7:0] run, input logic [7:0] w);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, run);
    repeat (20) @(posedge clk_i);
    rd(ADDR_COUNT);
    check("armed count", 8'h00, 8'h00, d);
    toggle(8'h02, w);
    rd(ADDR_CTRL);
    check("run cleared", run & 8'hef, run & 8'hef, d);
    rd(ADDR_COUNT);
    check("width", w - 8'h03, w + 8'h03, d);
    toggle(8'h02, 8'h0a);
    rd(ADDR_COUNT);
    check("held width", w - 8'h03, w + 8'h03, d);
    $display("test pulse %h done", run);
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(ADDR_CTRL);
    check("ctrl reset", CTRL_RESET, CTRL_RESET, d);
    rd(ADDR_COUNT);
    check("count reset", COUNT_RESET, COUNT_RESET, d);
    // timer: preload while stopped, held preload while running, wake and vector
    wr(ADDR_COUNT, 8'hfd);
    sys_tick_i <= 1'b0;
    wr(ADDR_CTRL, 8'h90);
    wr(ADDR_COUNT, 8'h10);
    rd(ADDR_COUNT);
    check("direct preload", 8'hfd, 8'hfd, d);
    low_power_i <= 1'b1;
    sys_tick_i <= 1'b1;
    wait_ovf();
    check("wake", 8'h01, 8'h01, {7'h00, saw_wake});
    check("no vector", 8'h00, 8'h00, {7'h00, saw_vec});
    check("req flag", 8'h01, 8'h01, {7'h00, irq_req_o});
    rd(ADDR_COUNT);
    check("reload", 8'h10, 8'h16, d);
    low_power_i <= 1'b0;
    irq_enable_i <= 1'b1;
    wait_ovf();
    check("vector", 8'h01, 8'h01, {7'h00, saw_vec});
    check("no wake", 8'h00, 8'h00, {7'h00, saw_wake});
    // software clear, then set flag before sleep to suppress the wake
    irq_flag_clr_i <= 1'b1;
    @(posedge clk_i);
    irq_flag_clr_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("flag clr", 8'h00, 8'h00, {7'h00, irq_req_o});
    irq_flag_set_i <= 1'b1;
    @(posedge clk_i);
    irq_flag_set_i <= 1'b0;
    irq_flag_i <= 1'b1;
    low_power_i <= 1'b1;
    wait_ovf();
    check("wake masked", 8'h00, 8'h00, {7'h00, saw_wake});
    check("vector kept", 8'h01, 8'h01, {7'h00, saw_vec});
    irq_flag_i <= 1'b0;
    low_power_i <= 1'b0;
    // prescale divide by 8 over 80 ticks
    wr(ADDR_CTRL, 8'h80);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'h93);
    repeat (79) @(posedge clk_i);
    wr(ADDR_CTRL, 8'h83);
    rd(ADDR_COUNT);
    check("div8", 8'h09, 8'h0b, d);
    $display("test timer done");
    // event: rising edges, then falling edges; pin starts low
    wr(ADDR_CTRL, 8'h40);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'h50);
    toggle(8'h03, 8'h04);
    rd(ADDR_COUNT);
    check("rise count", 8'h02, 8'h02, d);
    wr(ADDR_CTRL, 8'h58);
    toggle(8'h03, 8'h04);
    rd(ADDR_COUNT);
    check("fall count", 8'h04, 8'h04, d);
    rd(ADDR_CTRL);
    check("run kept", 8'h58, 8'h58, d);
    $display("test event done");
    // pulse width: high pulse then low pulse
    wr(ADDR_CTRL, 8'hc8);
    pulse(8'hd8, 8'h1e);
    toggle(8'h01, 8'h02);
    low_power_i <= 1'b1;
    pulse(8'hd0, 8'h14);
    low_power_i <= 1'b0;
    end_sim();
  end
endmodule // test_tmr_event_counter
